// ===== common/cssp_pkg.sv
// Overview of operation
// [R1] alu: add, logic, adjust, inc, rotate, swap
// [R2] carry out of bit 7, aux out of bit 3
// [R3] aux carry follows carry, feeds decimal adjust
// [R4] zero written to status bit 6 clears aux
// [R5] conditional jump loads target only when true
// [R6] branch tests: irq, flags, carry, acc, tests
// [R7] decrement register, branch when result nonzero
// [R8] status word moves to/from acc whole
// [R9] status bits 0-2 stack pointer, bit 3 one
// [R10] status bit 4 selects working bank
// [R11] status bit 5 user flag: complement, clear, test
// [R12] bit 7 carry, bit 6 aux carry
// [R13] call or interrupt pushes status bits 4-7
// [R14] stack at ram 8 to 23, two bytes
// [R15] push stores pair then increments pointer
// [R16] stack pointer wraps both ways
// [R17] return pops pc, status only when asked
// [R18] 12-bit pc increments for fetch
// [R19] increment wraps 11 low bits, keeps bit 11
// [R20] bank latch copied to bit 11 on jumps
// [R21] interrupt service holds pc bit 11 low
// [R22] fetch: low byte on bus during latch strobe
// [R23] bank 0 at ram 0, bank 1 at 24
// [R24] interrupt vectors 003 and 007
// [R25] stack pair: pc low byte, status/pc high
// [R26] reset clears program counter
package cssp_pkg;
  // ram map
  localparam logic [7:0] CSSP_STK_BASE = 8'h08;
  localparam logic [7:0] CSSP_BANK0_BASE = 8'h00;
  localparam logic [7:0] CSSP_BANK1_BASE = 8'h18;
  // program counter and reset values
  localparam logic [11:0] CSSP_PC_RESET = 12'h000;
  localparam logic [11:0] CSSP_VEC_EXT = 12'h003;
  localparam logic [11:0] CSSP_VEC_TMR = 12'h007;
  localparam logic [2:0] CSSP_SP_RESET = 3'h0;
  localparam logic [7:0] CSSP_BYTE_RESET = 8'h00;
  // status word field positions
  localparam int CSSP_SW_CY = 7;
  localparam int CSSP_SW_AC = 6;
  localparam int CSSP_SW_FLAG = 5;
  localparam int CSSP_SW_BS = 4;
  localparam int CSSP_SW_ONE = 3;
  localparam int CSSP_SW_SP = 0;
  // decimal adjust constants
  localparam logic [3:0] CSSP_BCD_MAX = 4'h9;
  localparam logic [8:0] CSSP_DA_LO = 9'h006;
  localparam logic [8:0] CSSP_DA_HI = 9'h060;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADDC, ALU_AND, ALU_OR, ALU_XOR, ALU_DA, ALU_INC, ALU_DEC,
    ALU_CPL, ALU_CLR, ALU_RL, ALU_RLC, ALU_RR, ALU_RRC, ALU_SWAP, ALU_LD
  } cssp_alu_op_t;

  typedef enum logic [3:0] {
    JUMP_ON_IRQ_LOW, JUMP_ON_USER_FLAG_A, JUMP_ON_USER_FLAG_B, JUMP_ON_TIMER_FLAG,
    JUMP_IF_CARRY, JUMP_IF_NO_CARRY, JUMP_IF_ACC_ZERO, JUMP_IF_ACC_NONZERO,
    JUMP_ON_ACC_BIT, JUMP_TEST_IN_A_HIGH, JUMP_TEST_IN_A_LOW,
    JUMP_TEST_IN_B_HIGH, JUMP_TEST_IN_B_LOW
  } cssp_cond_t;

  typedef enum logic [4:0] {
    CMD_NOP, CMD_ALU, CMD_SW_RD, CMD_SW_WR, CMD_JMP, CMD_CALL, CMD_JCOND,
    CMD_DEC_JMP, CMD_RET, CMD_RETR, CMD_INT_EXT, CMD_INT_TMR, CMD_MEM_LO,
    CMD_MEM_HI, CMD_REGS_LO, CMD_REGS_HI, CMD_CPL_FA, CMD_CLR_FA, CMD_CPL_FB,
    CMD_CLR_FB, CMD_CPL_C, CMD_CLR_C, CMD_FETCH
  } cssp_cmd_kind_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PUSH_HI, ST_POP_LO, ST_POP_HI, ST_POP_END, ST_DJ_RD, ST_DJ_WR,
    ST_FETCH_STB, ST_FETCH_CAP
  } cssp_fsm_t;

  typedef struct packed {
    logic valid;
    cssp_cmd_kind_t kind;
    cssp_alu_op_t alu;
    cssp_cond_t cond;
    logic [2:0] sel;
    logic [10:0] target;
    logic [7:0] imm;
  } cssp_cmd_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } cssp_ram_req_t;

  typedef struct packed {
    logic [7:0] bus_out;
    logic bus_oe;
    logic [3:0] port2;
    logic ale;
    logic program_store_strobe;
  } cssp_ext_t;

  typedef struct packed {
    cssp_fsm_t st;
    logic [7:0] acc;
    logic cy;
    logic ac;
    logic fa;
    logic fb;
    logic bs;
    logic [2:0] sp;
    logic [11:0] pc;
    logic bank_latch;
    logic isr;
    logic mark;
    logic [11:0] tgt;
    logic [7:0] lo;
    logic [7:0] instr;
    cssp_ram_req_t ram;
    cssp_ext_t ext;
  } cssp_state_t;

  // all-clear state, pc at its reset address
  localparam cssp_state_t CSSP_STATE_RESET = '{
    st: ST_IDLE, acc: CSSP_BYTE_RESET, sp: CSSP_SP_RESET, pc: CSSP_PC_RESET,
    tgt: CSSP_PC_RESET, lo: CSSP_BYTE_RESET, instr: CSSP_BYTE_RESET,
    ram: '0, ext: '0, default: 1'b0};
endpackage

// ===== hw/cssp_alu.sv
`timescale 1ns/1ns
module cssp_alu
(
  input wire cssp_pkg::cssp_alu_op_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] opnd,
  input wire logic cy_in,
  input wire logic ac_in,
  output logic [7:0] res,
  output logic cy_out,
  output logic ac_out
);
  import cssp_pkg::*;

  logic cin;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [8:0] da_lo;
  logic [8:0] da_hi;

  // [R1] operation set
  always_comb
  begin
    cin = (op == ALU_ADDC) ? cy_in : 1'b0;
    sum = {1'b0, acc} + {1'b0, opnd} + {8'h00, cin};
    nib = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
    da_lo = {1'b0, acc} + (((acc[3:0] > CSSP_BCD_MAX) || ac_in) ? CSSP_DA_LO : 9'h000);
    da_hi = da_lo + (((da_lo[7:4] > CSSP_BCD_MAX) || cy_in) ? CSSP_DA_HI : 9'h000);
    res = acc;
    cy_out = cy_in;
    ac_out = ac_in;
    case (op)
      // [R2] carry out of bit 7, aux out of bit 3
      ALU_ADD, ALU_ADDC:
      begin
        res = sum[7:0];
        cy_out = sum[8];
        ac_out = nib[4];
      end
      ALU_AND: res = acc & opnd;
      ALU_OR: res = acc | opnd;
      ALU_XOR: res = acc ^ opnd;
      // [R3] aux carry only feeds decimal adjust
      ALU_DA:
      begin
        res = da_hi[7:0];
        cy_out = cy_in | da_lo[8] | da_hi[8];
        ac_out = (acc[3:0] > CSSP_BCD_MAX);
      end
      ALU_INC: res = acc + 8'h01;
      ALU_DEC: res = acc - 8'h01;
      ALU_CPL: res = ~acc;
      ALU_CLR: res = 8'h00;
      ALU_RL: res = {acc[6:0], acc[7]};
      // [R3] rotates through carry move aux too
      ALU_RLC:
      begin
        res = {acc[6:0], cy_in};
        cy_out = acc[7];
        ac_out = acc[3];
      end
      ALU_RR: res = {acc[0], acc[7:1]};
      ALU_RRC:
      begin
        res = {cy_in, acc[7:1]};
        cy_out = acc[0];
        ac_out = acc[4];
      end
      ALU_SWAP: res = {acc[3:0], acc[7:4]};
      default: res = opnd;
    endcase
  end
endmodule

// ===== hw/cssp_cond.sv
`timescale 1ns/1ns
module cssp_cond
(
  input wire cssp_pkg::cssp_cond_t cond,
  input wire logic [2:0] sel,
  input wire logic [7:0] acc,
  input wire logic cy,
  input wire logic fa,
  input wire logic fb,
  input wire logic tf,
  input wire logic irq_n,
  input wire logic test_a,
  input wire logic test_b,
  output logic taken
);
  import cssp_pkg::*;

  // [R6] branch condition select
  always_comb
  begin
    case (cond)
      JUMP_ON_IRQ_LOW: taken = !irq_n;
      JUMP_ON_USER_FLAG_A: taken = fa;
      JUMP_ON_USER_FLAG_B: taken = fb;
      JUMP_ON_TIMER_FLAG: taken = tf;
      JUMP_IF_CARRY: taken = cy;
      JUMP_IF_NO_CARRY: taken = !cy;
      JUMP_IF_ACC_ZERO: taken = (acc == 8'h00);
      JUMP_IF_ACC_NONZERO: taken = (acc != 8'h00);
      JUMP_ON_ACC_BIT: taken = acc[sel];
      JUMP_TEST_IN_A_HIGH: taken = test_a;
      JUMP_TEST_IN_A_LOW: taken = !test_a;
      JUMP_TEST_IN_B_HIGH: taken = test_b;
      JUMP_TEST_IN_B_LOW: taken = !test_b;
      default: taken = 1'b0;
    endcase
  end
endmodule

// ===== hw/cssp_core.sv
`timescale 1ns/1ns
module cssp_core
(
  input wire logic mclk,
  input wire logic reset,
  input wire cssp_pkg::cssp_cmd_t cmd,
  output logic cmd_ready,
  input wire logic irq_n,
  input wire logic test_a,
  input wire logic test_b,
  input wire logic timer_flag,
  output cssp_pkg::cssp_ram_req_t ram_req,
  input wire logic [7:0] ram_rdata,
  output cssp_pkg::cssp_ext_t ext,
  input wire logic [7:0] bus_in,
  output logic [7:0] instr,
  output logic [7:0] acc,
  output logic [7:0] program_status_word,
  output logic [11:0] pc
);
  import cssp_pkg::*;

  cssp_state_t s_r;
  cssp_state_t s_nxt;
  logic take;
  logic taken;
  logic [7:0] alu_res;
  logic alu_cy;
  logic alu_ac;
  logic [7:0] dec_val;

  // [R14] stack pair address, two bytes per level
  function automatic logic [7:0] stk_addr(input logic [2:0] sp, input logic hi);
    stk_addr = CSSP_STK_BASE + {4'h0, sp, hi};
  endfunction

  // [R23] working register address per bank
  function automatic logic [7:0] reg_addr(input logic bs, input logic [2:0] idx);
    reg_addr = (bs ? CSSP_BANK1_BASE : CSSP_BANK0_BASE) + {5'h00, idx};
  endfunction

  // [R9] status word assembly, bit 3 reads one
  function automatic logic [7:0] status_of(input cssp_state_t s);
    status_of = 8'h00;
    status_of[CSSP_SW_SP +: 3] = s.sp;
    status_of[CSSP_SW_ONE] = 1'b1;
    status_of[CSSP_SW_BS] = s.bs;
    status_of[CSSP_SW_FLAG] = s.fa;
    status_of[CSSP_SW_AC] = s.ac;
    status_of[CSSP_SW_CY] = s.cy;
  endfunction

  // [R20] jump target takes bit 11 from bank latch
  // [R21] forced low during interrupt service
  function automatic logic [11:0] jump_tgt(input cssp_state_t s, input logic [10:0] t);
    jump_tgt = {s.bank_latch & ~s.isr, t};
  endfunction

  // arithmetic unit on accumulator and operand
  cssp_alu u_alu (
    .op(cmd.alu),
    .acc(s_r.acc),
    .opnd(cmd.imm),
    .cy_in(s_r.cy),
    .ac_in(s_r.ac),
    .res(alu_res),
    .cy_out(alu_cy),
    .ac_out(alu_ac)
  );

  // branch condition evaluation
  cssp_cond u_cond (
    .cond(cmd.cond),
    .sel(cmd.sel),
    .acc(s_r.acc),
    .cy(s_r.cy),
    .fa(s_r.fa),
    .fb(s_r.fb),
    .tf(timer_flag),
    .irq_n(irq_n),
    .test_a(test_a),
    .test_b(test_b),
    .taken(taken)
  );

  // outputs straight from state
  assign cmd_ready = (s_r.st == ST_IDLE);
  assign take = cmd.valid && cmd_ready;
  assign ram_req = s_r.ram;
  assign ext = s_r.ext;
  assign instr = s_r.instr;
  assign acc = s_r.acc;
  assign pc = s_r.pc;
  // [R8] whole status word visible at once
  assign program_status_word = status_of(s_r);
  assign dec_val = ram_rdata - 8'h01;

  // next state
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ram = '0;
    s_nxt.ext.bus_oe = 1'b0;
    s_nxt.ext.ale = 1'b0;
    s_nxt.ext.program_store_strobe = 1'b0;
    case (s_r.st)
      ST_IDLE:
      begin
        if (take)
        begin
          case (cmd.kind)
            // [R1] result back into accumulator
            CMD_ALU:
            begin
              s_nxt.acc = alu_res;
              // [R2] carry flags from alu
              // [R3] aux updated alongside carry
              s_nxt.cy = alu_cy;
              s_nxt.ac = alu_ac;
            end
            // [R8] status word read as a whole
            CMD_SW_RD: s_nxt.acc = status_of(s_r);
            // [R8] status word written as a whole
            CMD_SW_WR:
            begin
              s_nxt.sp = s_r.acc[CSSP_SW_SP +: 3];
              // [R10] bank select bit
              s_nxt.bs = s_r.acc[CSSP_SW_BS];
              s_nxt.fa = s_r.acc[CSSP_SW_FLAG];
              // [R4] zero in bit 6 clears aux carry
              // [R12] carry and aux positions
              s_nxt.ac = s_r.acc[CSSP_SW_AC];
              s_nxt.cy = s_r.acc[CSSP_SW_CY];
            end
            // [R20] unconditional jump
            CMD_JMP: s_nxt.pc = jump_tgt(s_r, cmd.target);
            // [R13] call and interrupts push pc and status
            // [R25] low byte of pc into lower location
            CMD_CALL, CMD_INT_EXT, CMD_INT_TMR:
            begin
              s_nxt.ram.addr = stk_addr(s_r.sp, 1'b0);
              s_nxt.ram.wdata = s_r.pc[7:0];
              s_nxt.ram.we = 1'b1;
              s_nxt.mark = (cmd.kind != CMD_CALL);
              // [R24] interrupt vectors
              if (cmd.kind == CMD_INT_EXT)
              begin
                s_nxt.tgt = CSSP_VEC_EXT;
              end
              else if (cmd.kind == CMD_INT_TMR)
              begin
                s_nxt.tgt = CSSP_VEC_TMR;
              end
              else
              begin
                s_nxt.tgt = jump_tgt(s_r, cmd.target);
              end
              s_nxt.st = ST_PUSH_HI;
            end
            // [R5] load target only when condition true
            CMD_JCOND:
            begin
              if (taken)
              begin
                s_nxt.pc = {s_r.pc[11], cmd.target};
              end
            end
            // [R7] read working register for decrement
            CMD_DEC_JMP:
            begin
              s_nxt.lo = reg_addr(s_r.bs, cmd.sel);
              s_nxt.ram.addr = reg_addr(s_r.bs, cmd.sel);
              s_nxt.ram.re = 1'b1;
              s_nxt.tgt = {s_r.pc[11], cmd.target};
              s_nxt.st = ST_DJ_RD;
            end
            // [R17] return decrements pointer first
            // [R16] 000 wraps to 111
            CMD_RET, CMD_RETR:
            begin
              s_nxt.sp = s_r.sp - 3'h1;
              s_nxt.ram.addr = stk_addr(s_r.sp - 3'h1, 1'b0);
              s_nxt.ram.re = 1'b1;
              s_nxt.mark = (cmd.kind == CMD_RETR);
              s_nxt.st = ST_POP_LO;
            end
            // [R20] bank latch set and clear
            CMD_MEM_LO: s_nxt.bank_latch = 1'b0;
            CMD_MEM_HI: s_nxt.bank_latch = 1'b1;
            // [R10] working bank select
            CMD_REGS_LO: s_nxt.bs = 1'b0;
            CMD_REGS_HI: s_nxt.bs = 1'b1;
            // [R11] user flags and carry, complement and clear
            CMD_CPL_FA: s_nxt.fa = ~s_r.fa;
            CMD_CLR_FA: s_nxt.fa = 1'b0;
            CMD_CPL_FB: s_nxt.fb = ~s_r.fb;
            CMD_CLR_FB: s_nxt.fb = 1'b0;
            CMD_CPL_C: s_nxt.cy = ~s_r.cy;
            CMD_CLR_C: s_nxt.cy = 1'b0;
            // [R22] low byte driven with latch strobe
            CMD_FETCH:
            begin
              s_nxt.ext.bus_out = s_r.pc[7:0];
              s_nxt.ext.bus_oe = 1'b1;
              s_nxt.ext.ale = 1'b1;
              s_nxt.ext.port2 = s_r.pc[11:8];
              s_nxt.st = ST_FETCH_STB;
            end
            default: s_nxt.st = ST_IDLE;
          endcase
        end
      end
      // [R15] upper byte, then pointer increments
      // [R25] status nibble high, pc bits 8-11 low
      ST_PUSH_HI:
      begin
        s_nxt.ram.addr = stk_addr(s_r.sp, 1'b1);
        s_nxt.ram.wdata = {s_r.cy, s_r.ac, s_r.fa, s_r.bs, s_r.pc[11:8]};
        s_nxt.ram.we = 1'b1;
        // [R16] 111 wraps to 000
        s_nxt.sp = s_r.sp + 3'h1;
        s_nxt.pc = s_r.tgt;
        if (s_r.mark)
        begin
          s_nxt.isr = 1'b1;
        end
        s_nxt.st = ST_IDLE;
      end
      ST_POP_LO:
      begin
        s_nxt.ram.addr = stk_addr(s_r.sp, 1'b1);
        s_nxt.ram.re = 1'b1;
        s_nxt.st = ST_POP_HI;
      end
      ST_POP_HI:
      begin
        s_nxt.lo = ram_rdata;
        s_nxt.st = ST_POP_END;
      end
      // [R17] restore pc, status only for the restoring return
      ST_POP_END:
      begin
        s_nxt.pc = {ram_rdata[3] & ~(s_r.isr & ~s_r.mark), ram_rdata[2:0], s_r.lo};
        if (s_r.mark)
        begin
          s_nxt.cy = ram_rdata[7];
          s_nxt.ac = ram_rdata[6];
          s_nxt.fa = ram_rdata[5];
          s_nxt.bs = ram_rdata[4];
          s_nxt.isr = 1'b0;
        end
        s_nxt.st = ST_IDLE;
      end
      ST_DJ_RD: s_nxt.st = ST_DJ_WR;
      // [R7] write back, branch on nonzero
      ST_DJ_WR:
      begin
        s_nxt.ram.addr = s_r.lo;
        s_nxt.ram.wdata = dec_val;
        s_nxt.ram.we = 1'b1;
        if (dec_val != 8'h00)
        begin
          s_nxt.pc = s_r.tgt;
        end
        s_nxt.st = ST_IDLE;
      end
      // [R22] strobe program store after latch
      ST_FETCH_STB:
      begin
        s_nxt.ext.program_store_strobe = 1'b1;
        s_nxt.st = ST_FETCH_CAP;
      end
      // [R18] capture instruction and count on
      // [R19] low 11 bits wrap, bit 11 kept
      ST_FETCH_CAP:
      begin
        s_nxt.instr = bus_in;
        s_nxt.pc = {s_r.pc[11], s_r.pc[10:0] + 11'h001};
        s_nxt.st = ST_IDLE;
      end
      default: s_nxt.st = ST_IDLE;
    endcase
  end

  // state register
  // [R26] reset clears program counter
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s_r <= CSSP_STATE_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (reset);

  unused_bit_one_a: // [R9]
    assert property (program_status_word[CSSP_SW_ONE] == 1'b1)
    else $error("status word bit 3 read as zero");

  isr_bank_low_a: // [R21]
    assert property ((s_r.isr && s_r.st == ST_IDLE) |-> !pc[11])
    else $error("pc bit 11 set during interrupt service");

  fetch_drive_a: // [R22]
    assert property (ext.bus_oe |-> ext.ale ##1 (ext.program_store_strobe && !ext.bus_oe))
    else $error("bus driven outside latch strobe");

  push_pair_a: // [R14]
    assert property ((s_r.st == ST_PUSH_HI) |-> (ram_req.we && ram_req.addr ==
      stk_addr(s_r.sp, 1'b0)) ##1 (ram_req.addr == stk_addr(s_r.sp - 3'h1, 1'b1)))
    else $error("stack pair address wrong");

  sp_push_inc_a: // [R15]
    assert property ((take && cmd.kind == CMD_CALL) |=> ##1
      (s_r.sp == $past(s_r.sp, 2) + 3'h1))
    else $error("stack pointer not incremented by push");

  cond_jump_a: // [R5]
    assert property ((take && cmd.kind == CMD_JCOND) |=> (s_r.pc == ($past(taken) ?
      {$past(s_r.pc[11]), $past(cmd.target)} : $past(s_r.pc))))
    else $error("conditional jump target wrong");

  ext_vector_a: // [R24]
    assert property ((take && cmd.kind == CMD_INT_EXT) |=> ##1 (s_r.pc == CSSP_VEC_EXT))
    else $error("external interrupt vector wrong");

  aux_clear_a: // [R4]
    assert property ((take && cmd.kind == CMD_SW_WR && !s_r.acc[CSSP_SW_AC]) |=> !s_r.ac)
    else $error("aux carry not cleared by status write");

  fetch_inc_a: // [R19]
    assert property ((s_r.st == ST_FETCH_CAP) |=> (pc[11] == $past(pc[11]) &&
      pc[10:0] == $past(pc[10:0]) + 11'h001))
    else $error("sequential increment wrong");

  call_seen_c: cover property (take && cmd.kind == CMD_CALL ##2 cmd_ready);
  retr_seen_c: cover property (take && cmd.kind == CMD_RETR ##3 s_r.st == ST_POP_END);
  fetch_seen_c: cover property (ext.ale ##1 ext.program_store_strobe);
  dec_taken_c: cover property (s_r.st == ST_DJ_WR && dec_val != 8'h00);
endmodule

// ===== sim/cssp_prog_mem.sv
`timescale 1ns/1ns
module cssp_prog_mem
(
  input wire logic mclk,
  input wire cssp_pkg::cssp_ext_t ext,
  output logic [7:0] bus_in
);
  import cssp_pkg::*;
  logic [11:0] addr_r = 12'h000;
  logic [7:0] last_r = 8'h00;
  // address latch
  // low byte only taken while the latch strobe shows it
  always @(posedge mclk)
  begin
    if (ext.ale && ext.bus_oe) addr_r <= {ext.port2, ext.bus_out};
    if (ext.program_store_strobe) last_r <= bus_in;
  end
  // data on strobe
  // released bus shows the inverse of the last byte, never a stale match
  assign bus_in = ext.program_store_strobe ? (addr_r[7:0] ^ {addr_r[11:8], 4'h5}) : ~last_r;
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ns
module tb;
  import cssp_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  cssp_cmd_t cmd = '0;
  logic cmd_ready;
  logic irq_n = 1'b0;
  logic test_a = 1'b1;
  logic test_b = 1'b0;
  logic timer_flag = 1'b1;
  cssp_ram_req_t ram_req;
  logic [7:0] ram_rdata = 8'h00;
  cssp_ext_t ext;
  logic [7:0] bus_in;
  logic [7:0] instr;
  logic [7:0] acc;
  logic [7:0] status;
  logic [11:0] pc;
  logic [11:0] pcb;
  logic [10:0] t;
  logic [7:0] mem [256];
  logic [12:0] jv = 13'b1_0010_0110_1001;
  cssp_cmd_kind_t fk [6] = '{CMD_REGS_HI, CMD_REGS_LO, CMD_CPL_FA, CMD_CLR_FA, CMD_CPL_C,
    CMD_CLR_C};
  logic [7:0] fe [6] = '{8'h18, 8'h08, 8'h28, 8'h08, 8'h88, 8'h08};
  int err_count = 0;
  int tests_run = 0;

  cssp_core dut_u (.mclk(mclk), .reset(reset), .cmd(cmd), .cmd_ready(cmd_ready), .irq_n(irq_n),
    .test_a(test_a), .test_b(test_b), .timer_flag(timer_flag), .ram_req(ram_req),
    .ram_rdata(ram_rdata), .ext(ext), .bus_in(bus_in), .instr(instr), .acc(acc),
    .program_status_word(status), .pc(pc));
  cssp_prog_mem prog_u (.mclk(mclk), .ext(ext), .bus_in(bus_in));

  // clock, 10 ns period
  initial
  begin
    forever #5 mclk = ~mclk;
  end

  // data ram, read byte ready the cycle after the request
  always @(posedge mclk)
  begin
    if (ram_req.we) mem[ram_req.addr] <= ram_req.wdata;
    if (ram_req.re) ram_rdata <= mem[ram_req.addr];
  end

  task automatic finish_test;
    $display("errors %0d, checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("unexpected %s exp %h got %h", n, e, g);
      err_count++;
    end
  endtask

  task automatic chk12(input string n, input logic [11:0] e, input logic [11:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("unexpected %s exp %h got %h", n, e, g);
      err_count++;
    end
  endtask

  // bounded wait for idle and the last stack or register write landed
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge mclk);
    #1;
    while ((cmd_ready !== 1'b1 || ram_req.we !== 1'b0) && n < 20)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 20)
    begin
      $display("unexpected ready timeout exp 1 got 0");
      err_count++;
      finish_test();
    end
  endtask

  // one command, taken at the next edge, valid dropped after it
  task automatic run(input cssp_cmd_kind_t k, input logic [10:0] tg, input logic [2:0] s = 3'h0,
      input cssp_cond_t cd = JUMP_ON_IRQ_LOW, input cssp_alu_op_t op = ALU_LD,
      input logic [7:0] im = 8'h00);
    cmd = '{valid: 1'b1, kind: k, alu: op, cond: cd, sel: s, target: tg, imm: im};
    @(posedge mclk);
    #1 cmd.valid = 1'b0;
    wait_ready();
  endtask

  task automatic alu(input cssp_alu_op_t op, input logic [7:0] im, input logic [7:0] e);
    run(CMD_ALU, 11'h000, 3'h0, JUMP_ON_IRQ_LOW, op, im);
    chk8("acc", e, acc);
  endtask

  task automatic wr_status(input logic [7:0] v);
    alu(ALU_LD, v, v);
    run(CMD_SW_WR, 11'h000);
  endtask

  // fetch with a look at each bus phase
  task automatic fetch;
    logic [11:0] a;
    a = pc;
    cmd = '{valid: 1'b1, kind: CMD_FETCH, alu: ALU_LD, cond: JUMP_ON_IRQ_LOW, default: '0};
    @(posedge mclk);
    #1 cmd.valid = 1'b0;
    chk8("bus_out", a[7:0], ext.bus_out);
    chk8("addr ctl", {a[11:8], 4'h3}, {ext.port2, 2'b00, ext.ale, ext.bus_oe});
    @(posedge mclk);
    #1;
    chk8("strobe", 8'h02, {6'h00, ext.program_store_strobe, ext.bus_oe});
    @(posedge mclk);
    #1;
    chk8("instr", a[7:0] ^ {a[11:8], 4'h5}, instr);
    chk12("pc inc", {a[11], a[10:0] + 11'h001}, pc);
    wait_ready();
  endtask

  // main sequence
  initial
  begin
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    mem[2] = 8'h02;
    mem[26] = 8'h03;
    repeat (16) @(posedge mclk);
    #1 reset = 1'b0;
    chk12("pc", 12'h000, pc);
    chk8("status", 8'h08, status);
    alu(ALU_LD, 8'hF0, 8'hF0);
    alu(ALU_ADD, 8'h20, 8'h10);
    chk8("flags", 8'h80, status & 8'hC0);
    alu(ALU_ADDC, 8'h08, 8'h19);
    chk8("flags", 8'h00, status & 8'hC0);
    alu(ALU_ADD, 8'h27, 8'h40);
    chk8("flags", 8'h40, status & 8'hC0);
    alu(ALU_DA, 8'h00, 8'h46);
    alu(ALU_AND, 8'h0F, 8'h06);
    alu(ALU_OR, 8'hF0, 8'hF6);
    alu(ALU_XOR, 8'hFF, 8'h09);
    alu(ALU_INC, 8'h00, 8'h0A);
    alu(ALU_DEC, 8'h00, 8'h09);
    alu(ALU_CPL, 8'h00, 8'hF6);
    alu(ALU_RL, 8'h00, 8'hED);
    alu(ALU_RR, 8'h00, 8'hF6);
    run(CMD_CLR_C, 11'h000);
    alu(ALU_RLC, 8'h00, 8'hEC);
    chk8("carry", 8'h80, status & 8'h80);
    alu(ALU_RRC, 8'h00, 8'hF6);
    chk8("carry", 8'h00, status & 8'h80);
    alu(ALU_SWAP, 8'h00, 8'h6F);
    alu(ALU_CLR, 8'h00, 8'h00);
    // decimal adjust of both nibbles carries out of bit 7
    alu(ALU_LD, 8'h9A, 8'h9A);
    alu(ALU_DA, 8'h00, 8'h00);
    chk8("carry", 8'h80, status & 8'h80);
    // aux carry set, then cleared by a whole status write
    alu(ALU_LD, 8'h19, 8'h19);
    alu(ALU_ADD, 8'h27, 8'h40);
    wr_status(8'hB5);
    chk8("status", 8'hBD, status);
    alu(ALU_LD, 8'h00, 8'h00);
    run(CMD_SW_RD, 11'h000);
    chk8("acc", 8'hBD, acc);
    wr_status(8'h00);
    for (int i = 0; i < 6; i++)
    begin
      run(fk[i], 11'h000);
      chk8("status", fe[i], status);
    end
    // every branch test, once true and once false
    for (int p = 0; p < 2; p++)
    begin
      if (p == 1)
      begin
        run(CMD_CPL_FA, 11'h000);
        run(CMD_CPL_FB, 11'h000);
        run(CMD_CPL_C, 11'h000);
        irq_n = 1'b1;
        test_a = 1'b0;
        test_b = 1'b1;
        timer_flag = 1'b0;
      end
      alu(ALU_LD, (p == 1) ? 8'h80 : 8'h00, (p == 1) ? 8'h80 : 8'h00);
      for (int i = 0; i < 13; i++)
      begin
        pcb = pc;
        t = 11'h100 + 11'(i + 16 * p);
        run(CMD_JCOND, t, 3'h7, cssp_cond_t'(4'(i)));
        chk12("jump pc", (jv[i] ^ p[0]) ? {pcb[11], t} : pcb, pc);
      end
    end
    wr_status(8'h00);
    run(CMD_CLR_FB, 11'h000);
    // fetch at the 2K edge, both banks
    run(CMD_JMP, 11'h7FF);
    chk12("pc", 12'h7FF, pc);
    fetch();
    run(CMD_MEM_HI, 11'h000);
    run(CMD_JMP, 11'h7FF);
    chk12("pc", 12'hFFF, pc);
    fetch();
    // call then return with and without status restore
    wr_status(8'hA0);
    run(CMD_CALL, 11'h123);
    chk12("pc", 12'h923, pc);
    chk8("stack lo", 8'h00, mem[8]);
    chk8("stack hi", 8'hA8, mem[9]);
    chk8("status", 8'hA9, status);
    wr_status(8'h01);
    run(CMD_RETR, 11'h000);
    chk12("pc", 12'h800, pc);
    chk8("status", 8'hA8, status);
    run(CMD_CALL, 11'h123);
    wr_status(8'h01);
    run(CMD_RET, 11'h000);
    chk12("pc", 12'h800, pc);
    chk8("status", 8'h08, status);
    // nine nested calls, then underflow
    for (int k = 0; k < 9; k++) run(CMD_CALL, 11'h010 + 11'(k));
    chk8("stack lo", 8'h17, mem[8]);
    chk8("status", 8'h09, status);
    run(CMD_RET, 11'h000);
    chk12("pc", 12'h817, pc);
    run(CMD_RET, 11'h000);
    chk8("status", 8'h0F, status);
    chk12("pc", 12'h816, pc);
    wr_status(8'h00);
    // interrupt entry, bit 11 held low in service
    run(CMD_INT_EXT, 11'h000);
    chk12("pc", 12'h003, pc);
    chk8("stack hi", 8'h08, mem[9]);
    run(CMD_JMP, 11'h400);
    chk12("pc", 12'h400, pc);
    run(CMD_RETR, 11'h000);
    chk12("pc", 12'h816, pc);
    run(CMD_INT_TMR, 11'h000);
    chk12("pc", 12'h007, pc);
    run(CMD_RETR, 11'h000);
    // decrement and branch, both banks
    run(CMD_DEC_JMP, 11'h055, 3'h2);
    chk8("reg", 8'h01, mem[2]);
    chk12("pc", 12'h855, pc);
    run(CMD_DEC_JMP, 11'h066, 3'h2);
    chk12("pc", 12'h855, pc);
    run(CMD_REGS_HI, 11'h000);
    run(CMD_DEC_JMP, 11'h077, 3'h2);
    chk8("reg", 8'h02, mem[26]);
    chk8("reg", 8'h00, mem[2]);
    chk12("pc", 12'h877, pc);
    // bank latch cleared, jump lands below 2K
    run(CMD_MEM_LO, 11'h000);
    run(CMD_JMP, 11'h123);
    chk12("pc", 12'h123, pc);
    finish_test();
  end
endmodule
